// ==== core/isr_pkg.sv ====
package isr_pkg;

   // ---------------------------------------------------------------
   // slave peripheral address map (byte pointer values)
   // ---------------------------------------------------------------
   localparam logic [7:0] ISR_PA_RADDR_B0 = 8'h10;
   localparam logic [7:0] ISR_PA_RADDR_B3 = 8'h13;
   localparam logic [7:0] ISR_PA_RDATA_B0 = 8'h14;
   localparam logic [7:0] ISR_PA_RDATA_B3 = 8'h17;
   localparam logic [7:0] ISR_PA_ACC_STAT = 8'h20;

   // ---------------------------------------------------------------
   // register bus offsets of the two visible registers
   // ---------------------------------------------------------------
   localparam logic [23:0] ISR_OFS_INDIRECT_READ_ADDRESS = 24'h01D210;
   localparam logic [23:0] ISR_OFS_INDIRECT_READ_DATA = 24'h01D214;

   // ---------------------------------------------------------------
   // reset values, fields and arithmetic constants
   // ---------------------------------------------------------------
   localparam logic [31:0] ISR_RADDR_RESET = 32'h0000_0000;
   localparam logic [31:0] ISR_RDATA_RESET = 32'h0000_0000;
   localparam logic [7:0] ISR_PTR_RESET = 8'h00;
   localparam logic [31:0] ISR_RADDR_STEP = 32'h0000_0004;
   localparam logic [7:0] ISR_ALIGN_MASK = 8'hFC;
   localparam int ISR_ADDR_SIG_BITS = 24;
   localparam int ISR_ACCESS_SUCCESS_FLAG_POS = 7;
   localparam logic [1:0] ISR_SIZE_FOUR_BYTE = 2'h3;

   typedef enum logic {
      ISR_IDLE,
      ISR_BUS_WAIT
   } isr_state_t;

   // byte k of a word, k = 0 is the least significant byte
   function automatic logic [7:0] isr_byte(input logic [31:0] w, input logic [1:0] k);
      isr_byte = w[8 * k +: 8];
   endfunction

endpackage

// ==== core/isr_ptr_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface isr_ptr_if;
   logic load;       // master sets the peripheral address
   logic [7:0] load_val;
   logic step;       // one byte transferred
   logic step_rd;    // that byte was a read
   logic [7:0] ptr;  // current peripheral address

   modport ctl (output load, output load_val, output step, output step_rd, input ptr);
   modport ptr_side (input load, input load_val, input step, input step_rd, output ptr);
endinterface
`default_nettype wire

// ==== core/isr_ptr.sv ====
`timescale 1ns/100ps
`default_nettype none
module isr_ptr
   import isr_pkg::*;
(
   input wire logic i_clk_sys,   // core clock
   input wire logic i_reset,     // synchronous reset, high
   input wire logic i_ce,        // clock enable
   isr_ptr_if.ptr_side pif       // pointer controls
);

   typedef struct packed {
      logic [7:0] ptr;
   } isr_ptr_st_t;

   isr_ptr_st_t st_reg;
   isr_ptr_st_t st_next;

   // ---------------------------------------------------------------
   // pointer next value
   // ---------------------------------------------------------------
   // a read of the top data byte folds back so block reads never leave the window
   always_comb begin
      st_next = st_reg;
      if (pif.load) begin
         st_next.ptr = pif.load_val;
      end else if (pif.step) begin
         if (pif.step_rd && st_reg.ptr == ISR_PA_RDATA_B3) begin
            st_next.ptr = ISR_PA_RDATA_B0;
         end else begin
            st_next.ptr = st_reg.ptr + 8'h01;
         end
      end
   end

   // state register
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         st_reg.ptr <= ISR_PTR_RESET;
      end else if (i_ce) begin
         st_reg <= st_next;
      end
   end

   assign pif.ptr = st_reg.ptr;

endmodule
`default_nettype wire

// ==== core/isr_bridge.sv ====
//
// Behaviour
// - read address is read/write from the slave side, read-only from the register bus
// - read address bytes sit at peripheral addresses 0x10 to 0x13
// - two lowest read address bits are always zero and ignore writes
// - only the low 24 address bits reach the internal bus; top byte is stored only
// - with auto-increment set, a good four-byte internal read at 0x14 adds 4 to the address
// - read data register cannot be written from either side
// - read data bytes sit at 0x14 (least significant) to 0x17 (most significant)
// - with four-byte size, reading 0x14 runs an internal read and loads the data unless the read fails
// - reads of 0x15 to 0x17 return stored bytes and start no internal access
// - after reading 0x17 the peripheral pointer wraps back to 0x14
// - a write at 0x17 moves the pointer on to 0x18, no wrap
// - the peripheral address selects which byte of the word is returned
// - read address and read data both reset to zero
// - success flag sets on a good internal read, clears when read at 0x20
//
`timescale 1ns/100ps
`default_nettype none
module isr_bridge
   import isr_pkg::*;
(
   input wire logic i_clk_sys,              // core clock, 25 MHz
   input wire logic i_reset,                // synchronous reset, high
   input wire logic i_ce,                   // clock enable, freezes all state when low
   input wire logic i_read_auto_increment,  // add 4 after each good internal read at 0x14
   input wire logic [1:0] i_read_access_size, // internal read size code
   input wire logic i_slv_ptr_load,         // master sets the peripheral address
   input wire logic [7:0] i_slv_ptr_val,    // new peripheral address
   input wire logic i_slv_wr_valid,         // master writes one byte
   input wire logic [7:0] i_slv_wr_data,    // written byte
   input wire logic i_slv_rd_req,           // master asks for one byte
   output logic o_slv_rd_valid,             // read byte ready, one cycle
   output logic [7:0] o_slv_rd_data,        // read byte
   output logic o_slv_busy,                 // internal read in flight
   output logic o_rb_req,                   // internal bus read request
   output logic [23:0] o_rb_addr,           // internal bus word address
   input wire logic i_rb_ack,               // internal bus answer
   input wire logic i_rb_err,               // internal bus failed
   input wire logic [31:0] i_rb_data,       // internal bus read data
   input wire logic i_hb_rd,                // host register read strobe
   input wire logic [23:0] i_hb_addr,       // host register offset
   output logic o_hb_ack,                   // host read answer, one cycle
   output logic [31:0] o_hb_data,           // host read data
   output logic o_access_success_flag       // status flag level
);

   typedef struct packed {
      isr_state_t state;
      logic busy;
      logic [31:0] raddr;
      logic [31:0] rdata;
      logic access_success_flag;
      logic rd_valid;
      logic [7:0] rd_data;
      logic rb_req;
      logic [23:0] rb_addr;
      logic hb_ack;
      logic [31:0] hb_data;
   } isr_st_t;

   isr_st_t st_reg;
   isr_st_t st_next;
   logic step;
   logic step_rd;

   isr_ptr_if pif ();

   // ---------------------------------------------------------------
   // peripheral address window decode
   // ---------------------------------------------------------------
   // shared by the write and read paths so both always agree on the map;
   // a change of window edges then lands in one place only
   function automatic logic isr_in_addr_win(input logic [7:0] p);
      isr_in_addr_win = (p >= ISR_PA_RADDR_B0) && (p <= ISR_PA_RADDR_B3);
   endfunction

   function automatic logic isr_in_data_win(input logic [7:0] p);
      isr_in_data_win = (p >= ISR_PA_RDATA_B0) && (p <= ISR_PA_RDATA_B3);
   endfunction

   // ---------------------------------------------------------------
   // peripheral address pointer
   // ---------------------------------------------------------------
   isr_ptr u_ptr (
      .i_clk_sys (i_clk_sys),
      .i_reset (i_reset),
      .i_ce (i_ce),
      .pif (pif.ptr_side)
   );

   assign pif.load = i_slv_ptr_load;
   assign pif.load_val = i_slv_ptr_val;
   assign pif.step = step;
   assign pif.step_rd = step_rd;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   // one slave request is handled per cycle, host reads alongside: pointer load beats write beats read
   always_comb begin
      st_next = st_reg;
      step = 1'b0;
      step_rd = 1'b0;
      st_next.rd_valid = 1'b0;
      st_next.hb_ack = 1'b0;

      // host side only reads; no write path exists for either register
      if (i_hb_rd) begin
         st_next.hb_ack = 1'b1;
         case (i_hb_addr)
            ISR_OFS_INDIRECT_READ_ADDRESS: st_next.hb_data = st_reg.raddr;
            ISR_OFS_INDIRECT_READ_DATA: st_next.hb_data = st_reg.rdata;
            default: st_next.hb_data = 32'h0000_0000;
         endcase
      end

      case (st_reg.state)
         ISR_IDLE: begin
            if (i_slv_ptr_load) begin
               // pointer load handled in the pointer module
            end else if (i_slv_wr_valid) begin
               step = 1'b1;
               if (isr_in_addr_win(pif.ptr)) begin
                  if (pif.ptr == ISR_PA_RADDR_B0) begin
                     st_next.raddr[7:0] = i_slv_wr_data & ISR_ALIGN_MASK;
                  end else begin
                     // top byte is kept but never driven onto the bus
                     st_next.raddr[8 * pif.ptr[1:0] +: 8] = i_slv_wr_data;
                  end
               end
               // data and status bytes are read-only, writes there are dropped
            end else if (i_slv_rd_req) begin
               if (pif.ptr == ISR_PA_RDATA_B0 && i_read_access_size == ISR_SIZE_FOUR_BYTE) begin
                  st_next.rb_req = 1'b1;
                  st_next.rb_addr = {st_reg.raddr[ISR_ADDR_SIG_BITS - 1:2], 2'b00};
                  st_next.state = ISR_BUS_WAIT;
                  // busy rises with the request so the master side stalls on a flop
                  st_next.busy = 1'b1;
               end else begin
                  step = 1'b1;
                  step_rd = 1'b1;
                  st_next.rd_valid = 1'b1;
                  if (isr_in_addr_win(pif.ptr)) begin
                     st_next.rd_data = isr_byte(st_reg.raddr, pif.ptr[1:0]);
                  end else if (isr_in_data_win(pif.ptr)) begin
                     st_next.rd_data = isr_byte(st_reg.rdata, pif.ptr[1:0]);
                  end else if (pif.ptr == ISR_PA_ACC_STAT) begin
                     st_next.rd_data = 8'h00;
                     st_next.rd_data[ISR_ACCESS_SUCCESS_FLAG_POS] = st_reg.access_success_flag;
                     st_next.access_success_flag = 1'b0;
                  end else begin
                     st_next.rd_data = 8'h00;
                  end
               end
            end
         end
         ISR_BUS_WAIT: begin
            // master writes and reads are not taken while the internal read is in flight; pointer loads still are
            if (i_rb_ack) begin
               st_next.rb_req = 1'b0;
               st_next.state = ISR_IDLE;
               // busy falls at the same edge that hands the byte over
               st_next.busy = 1'b0;
               st_next.rd_valid = 1'b1;
               step = 1'b1;
               step_rd = 1'b1;
               if (!i_rb_err) begin
                  st_next.rdata = i_rb_data;
                  st_next.rd_data = isr_byte(i_rb_data, 2'h0);
                  st_next.access_success_flag = 1'b1;
                  if (i_read_auto_increment) begin
                     st_next.raddr = st_reg.raddr + ISR_RADDR_STEP;
                  end
               end else begin
                  // failed read keeps the old word so the master sees stale but stable data
                  st_next.rd_data = isr_byte(st_reg.rdata, 2'h0);
               end
            end
         end
         default: begin
            // an illegal state drops any request and frees the master side
            st_next.state = ISR_IDLE;
            st_next.busy = 1'b0;
            st_next.rb_req = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         st_reg.state <= ISR_IDLE;
         st_reg.busy <= 1'b0;
         st_reg.raddr <= ISR_RADDR_RESET;
         st_reg.rdata <= ISR_RDATA_RESET;
         st_reg.access_success_flag <= 1'b0;
         st_reg.rd_valid <= 1'b0;
         st_reg.rd_data <= 8'h00;
         st_reg.rb_req <= 1'b0;
         st_reg.rb_addr <= 24'h000000;
         st_reg.hb_ack <= 1'b0;
         st_reg.hb_data <= 32'h0000_0000;
      end else if (i_ce) begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign o_slv_rd_valid = st_reg.rd_valid;
   assign o_slv_rd_data = st_reg.rd_data;
   assign o_slv_busy = st_reg.busy;
   assign o_rb_req = st_reg.rb_req;
   assign o_rb_addr = st_reg.rb_addr;
   assign o_hb_ack = st_reg.hb_ack;
   assign o_hb_data = st_reg.hb_data;
   assign o_access_success_flag = st_reg.access_success_flag;

endmodule
`default_nettype wire

// ==== verif/isr_bridge_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// port checks of the indirect read bridge
// ---------------------------------------------------------------
module isr_bridge_checker (
   input wire logic i_clk_sys,            // clock
   input wire logic i_reset,              // reset
   input wire logic i_ce,                 // enable
   input wire logic i_slv_ptr_load,       // pointer load
   input wire logic i_slv_wr_valid,       // byte write
   input wire logic i_slv_rd_req,         // byte read
   input wire logic o_slv_rd_valid,       // read answer
   input wire logic [7:0] o_slv_rd_data,  // read byte
   input wire logic o_slv_busy,           // busy
   input wire logic o_rb_req,             // bus request
   input wire logic [23:0] o_rb_addr,     // bus address
   input wire logic i_rb_ack,             // bus answer
   input wire logic i_rb_err,             // bus fault
   input wire logic i_hb_rd,              // host read
   input wire logic o_hb_ack,             // host answer
   input wire logic o_access_success_flag // flag
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   logic done;
   // the bridge takes an answer whenever its request stands and the enable is high
   assign done = o_rb_req && i_rb_ack && i_ce;
   chk_rb_aligned: assert property (o_rb_req |-> o_rb_addr[1:0] == 2'h0)
      else $error("bus address not word aligned");
   chk_rb_held: assert property (o_rb_req && !done |=> o_rb_req && $stable(o_rb_addr))
      else $error("bus request dropped before answer");
   chk_rb_release: assert property (done |=> !o_rb_req && !o_slv_busy && o_slv_rd_valid)
      else $error("bus answer not passed on");
   chk_busy_tracks: assert property (o_rb_req |-> o_slv_busy)
      else $error("bus request while not busy");
   chk_rd_answer: assert property (i_ce && i_slv_rd_req && !i_slv_ptr_load && !i_slv_wr_valid && !o_slv_busy
      |=> o_slv_rd_valid || o_rb_req)
      else $error("byte read left without answer");
   chk_flag_set: assert property (done && !i_rb_err |=> o_access_success_flag)
      else $error("success flag not set");
   chk_data_hold: assert property (!o_slv_rd_valid |-> $stable(o_slv_rd_data))
      else $error("read byte changed without answer");
   chk_hb_answer: assert property ($past(i_ce) |-> o_hb_ack == $past(i_hb_rd))
      else $error("host answer timing wrong");
endmodule
bind isr_bridge isr_bridge_checker isr_bridge_checker_inst (.*);
`default_nettype wire

// ==== verif/isr_rb_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// internal bus responder, settable delay and fault
// ---------------------------------------------------------------
module isr_rb_model (
   input wire logic i_clk_sys,        // clock
   input wire logic i_reset,          // reset
   input wire logic o_rb_req,         // request
   input wire logic [23:0] o_rb_addr, // address
   input wire logic [3:0] i_delay,    // wait cycles
   input wire logic i_fail,           // fault answer
   output logic i_rb_ack,             // answer pulse
   output logic i_rb_err,             // fault flag
   output logic [31:0] i_rb_data      // read word
);
   logic [3:0] cnt_reg;
   logic [31:0] word;
   // word is a pattern of the address; outside the answer the inverse, so stale data never matches
   assign word = {o_rb_addr[7:0] ^ 8'hC3, o_rb_addr};
   assign i_rb_data = i_rb_ack ? word : ~word;
   assign i_rb_err = i_rb_ack & i_fail;
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || i_rb_ack || !o_rb_req) begin
         cnt_reg <= 4'h0;
         i_rb_ack <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
         i_rb_ack <= (cnt_reg == i_delay);
      end
   end
endmodule
`default_nettype wire

// ==== verif/isr_bridge_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module isr_bridge_tb_top
   import isr_pkg::*;
;
   logic i_clk_sys, i_reset, i_ce, i_read_auto_increment, i_slv_ptr_load, i_slv_wr_valid, i_slv_rd_req, i_hb_rd;
   logic i_rb_ack, i_rb_err, i_fail, o_slv_rd_valid, o_slv_busy, o_rb_req, o_hb_ack, o_access_success_flag;
   logic [1:0] i_read_access_size;
   logic [3:0] i_delay;
   logic [7:0] i_slv_ptr_val, i_slv_wr_data, o_slv_rd_data, b;
   logic [23:0] o_rb_addr, i_hb_addr;
   logic [31:0] i_rb_data, o_hb_data, w;
   int error_cnt = 0;
   int n_compared = 0;
   isr_bridge isr_bridge_inst (.*);
   isr_rb_model isr_rb_model_inst (.*);
   initial begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one slave request for one cycle: pointer load or byte write
   task automatic put(input logic ld, input logic [7:0] v);
      {i_slv_ptr_load, i_slv_wr_valid, i_slv_ptr_val, i_slv_wr_data} = {ld, !ld, v, v};
      @(negedge i_clk_sys);
      {i_slv_ptr_load, i_slv_wr_valid} = 2'h0;
      @(negedge i_clk_sys);
   endtask
   // bounded wait, since a slow bus read stretches the answer
   task automatic rd(output logic [7:0] d);
      int k;
      i_slv_rd_req = 1'b1;
      @(negedge i_clk_sys);
      i_slv_rd_req = 1'b0;
      for (k = 0; k < 40 && o_slv_rd_valid !== 1'b1; k++) @(negedge i_clk_sys);
      if (k == 40) begin
         chk("read timeout", 32'h0, 32'h1);
         summarize();
      end else begin
         d = o_slv_rd_data;
         @(negedge i_clk_sys);
      end
   endtask
   task automatic rdw(input logic [31:0] exp, input string name);
      for (int i = 0; i < 4; i++) begin
         rd(b);
         chk(name, {24'h0, b}, {24'h0, exp[8 * i +: 8]});
      end
   endtask
   task automatic hb(input logic [23:0] a, input logic [31:0] exp, input string name);
      {i_hb_rd, i_hb_addr} = {1'b1, a};
      @(negedge i_clk_sys);
      i_hb_rd = 1'b0;
      chk({name, " ack"}, {31'h0, o_hb_ack}, 32'h1);
      chk(name, o_hb_data, exp);
      @(negedge i_clk_sys);
   endtask
   // word the bus model returns for an address
   function automatic logic [31:0] bw(input logic [23:0] a);
      bw = {a[7:0] ^ 8'hC3, a};
   endfunction
   initial begin
      {i_ce, i_read_auto_increment, i_slv_ptr_load, i_slv_wr_valid, i_slv_rd_req, i_hb_rd, i_fail} = 7'h40;
      {i_read_access_size, i_delay, i_slv_ptr_val, i_slv_wr_data, i_hb_addr} = {ISR_SIZE_FOUR_BYTE, 44'h0};
      i_reset = 1'b1;
      repeat (20) @(negedge i_clk_sys);
      i_reset = 1'b0;
      hb(ISR_OFS_INDIRECT_READ_ADDRESS, ISR_RADDR_RESET, "address reset");
      hb(ISR_OFS_INDIRECT_READ_DATA, ISR_RDATA_RESET, "data reset");
      // address bytes go in least significant first; the two low bits drop
      w = 32'hAB341237;
      put(1'b1, ISR_PA_RADDR_B0);
      for (int i = 0; i < 4; i++) put(1'b0, w[8 * i +: 8]);
      put(1'b1, ISR_PA_RADDR_B0);
      rdw(32'hAB341234, "address bytes");
      hb(ISR_OFS_INDIRECT_READ_ADDRESS, 32'hAB341234, "address host");
      // data bytes refuse writes and the pointer runs on past the last one
      put(1'b1, ISR_PA_RDATA_B0);
      for (int i = 0; i < 4; i++) put(1'b0, 8'hFF);
      rd(b);
      chk("byte after data", {24'h0, b}, 32'h0);
      hb(ISR_OFS_INDIRECT_READ_DATA, 32'h0, "data unwritten");
      // block read by auto-increment, pointer wrapping between words
      i_read_auto_increment = 1'b1;
      put(1'b1, ISR_PA_RDATA_B0);
      rdw(bw(24'h341234), "word 0");
      rdw(bw(24'h341238), "word 1");
      hb(ISR_OFS_INDIRECT_READ_ADDRESS, 32'hAB34123C, "address step");
      hb(ISR_OFS_INDIRECT_READ_DATA, bw(24'h341238), "data host");
      for (int i = 0; i < 2; i++) begin
         put(1'b1, ISR_PA_ACC_STAT);
         rd(b);
         chk("success flag", {24'h0, b}, i == 0 ? 32'h80 : 32'h0);
      end
      // slow failed read keeps data, address and flag
      {i_fail, i_delay} = {1'b1, 4'h6};
      w = bw(24'h341238);
      put(1'b1, ISR_PA_RDATA_B0);
      rd(b);
      chk("faulted byte", {24'h0, b}, {24'h0, w[7:0]});
      put(1'b1, ISR_PA_ACC_STAT);
      rd(b);
      chk("flag after fault", {24'h0, b}, 32'h0);
      // other size codes return the stored byte with no bus read
      i_fail = 1'b0;
      for (int s = 0; s < 3; s++) begin
         i_read_access_size = s[1:0];
         put(1'b1, ISR_PA_RDATA_B0);
         rd(b);
         chk("no bus read", {24'h0, b}, {24'h0, w[7:0]});
      end
      // a low enable freezes the pointer, so this load is lost and 0x15 is read
      i_ce = 1'b0;
      put(1'b1, ISR_PA_ACC_STAT);
      i_ce = 1'b1;
      rd(b);
      chk("enable freeze", {24'h0, b}, {24'h0, w[15:8]});
      hb(ISR_OFS_INDIRECT_READ_ADDRESS, 32'hAB34123C, "address kept");
      // a second reset in mid-run clears both registers again
      i_reset = 1'b1;
      repeat (2) @(negedge i_clk_sys);
      i_reset = 1'b0;
      hb(ISR_OFS_INDIRECT_READ_ADDRESS, ISR_RADDR_RESET, "address rereset");
      hb(ISR_OFS_INDIRECT_READ_DATA, ISR_RDATA_RESET, "data rereset");
      summarize();
   end
endmodule
`default_nettype wire
